// ### rtl/pld_power_pkg.sv
package pld_power_pkg;

	// ----------------------------------------------------------------
	// Register map (word aligned)
	// ----------------------------------------------------------------
	localparam logic [11:0] OFFSET_CTRL_FIRST = 12'h000;
	localparam logic [11:0] OFFSET_CTRL_SECOND = 12'h004;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int BIT_APD_ENABLE = 1;
	localparam int BIT_TURBO_OFF = 3;
	localparam int BIT_ARRAY_CLK_OFF = 4;
	localparam int BIT_MCELL_CLK_OFF = 5;
	localparam int BIT_WR_OFF = 2;
	localparam int BIT_RD_OFF = 3;
	localparam int BIT_PSEN_OFF = 4;
	localparam int BIT_ALE_OFF = 5;

	// Writable bits; the rest read as zero
	localparam logic [7:0] USED_MASK_FIRST = 8'h3A;
	localparam logic [7:0] USED_MASK_SECOND = 8'h3C;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RESET_CTRL_FIRST = 8'h00;
	localparam logic [7:0] RESET_CTRL_SECOND = 8'h00;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam int STANDBY_QUIET_NS = 70;
	localparam int STANDBY_CYCLES_INT = (STANDBY_QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] STANDBY_CYCLES = 4'(STANDBY_CYCLES_INT);
	localparam int APD_COUNT_W = 4;
	localparam logic [3:0] APD_LIMIT = 4'hF;

	// ----------------------------------------------------------------
	// Power-down states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		PS_ACTIVE = 2'b01,
		PS_DOWN = 2'b10
	} pd_state_t;

endpackage

// ### rtl/apd_counter.sv
`timescale 1ns/100ps
module apd_counter
	import pld_power_pkg::*;
#(
	parameter int CNT_W = APD_COUNT_W,
	parameter logic [CNT_W-1:0] LIMIT = APD_LIMIT
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic enable,
	input wire logic tick,
	input wire logic restart,
	output logic [CNT_W-1:0] count,
	output logic done
);

	// ----------------------------------------------------------------
	// Idle counter, saturating at the limit
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= '0;
		end else if (!enable || restart) begin
			count <= '0;
		end else if (tick && count != LIMIT) begin
			count <= count + 1'b1;
		end
	end

	assign done = enable && (count == LIMIT);

endmodule

// ### rtl/power_reg_apb.sv
`timescale 1ns/100ps
module power_reg_apb
	import pld_power_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [7:0] ctrl_first,
	output logic [7:0] ctrl_second
);

	logic hit_first;
	logic hit_second;
	logic access;

	assign hit_first = (paddr == ADDR_W'(OFFSET_CTRL_FIRST));
	assign hit_second = (paddr == ADDR_W'(OFFSET_CTRL_SECOND));
	assign access = psel && penable;
	// Zero wait states; unmapped addresses answer with an error
	assign pready = 1'b1;
	assign pslverr = access && !(hit_first || hit_second);

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_first <= RESET_CTRL_FIRST;
		end else if (access && pwrite && hit_first) begin
			ctrl_first <= pwdata[7:0] & USED_MASK_FIRST;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_second <= RESET_CTRL_SECOND;
		end else if (access && pwrite && hit_second) begin
			ctrl_second <= pwdata[7:0] & USED_MASK_SECOND;
		end
	end

	// Read data captured in setup phase, stable through access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (psel && !penable && !pwrite) begin
			if (hit_first) begin
				prdata <= {24'h000000, ctrl_first};
			end else if (hit_second) begin
				prdata <= {24'h000000, ctrl_second};
			end else begin
				prdata <= '0;
			end
		end
	end

endmodule

// ### rtl/pld_power_gating_control.sv
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
// Overview of operation
// - Bit 3 of first register selects speed
// - Low-power mode enters standby when inputs quiet
// - Speed bit zero means full power, no standby
// - Bit 1 of first register enables auto power-down
// - Bit 4 gates external clock from array
// - Array clock transitions wake logic when bit zero
// - Bit 5 gates external clock from macrocells
// - External clock feeds array and macrocells separately
// - Second register bits 2-5 gate bus strobes
// - Chip select low enables memories and I/O
// - Chip select high disables memories, logic runs
// - Battery indicator shows main below standby supply, only while battery routed
// - Power-down after fifteen quiet strobe clock periods
// - Leave power-down on ALE strobe edge, select, reset
// - Power-down counter sees ungated external clock
// - Full speed after reset, speed bit zero
module pld_power_gating_control
	import pld_power_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ext_logic_clock,
	input wire logic wr_strobe,
	input wire logic rd_strobe,
	input wire logic psen_strobe,
	input wire logic ale_strobe,
	input wire logic chip_select_n,
	input wire logic device_reset,
	input wire logic main_below_standby,
	input wire logic battery_route,
	output logic array_clock,
	output logic macrocell_clock,
	output logic array_wr,
	output logic array_rd,
	output logic array_psen,
	output logic array_ale,
	output logic power_down_flag,
	output logic memories_enable,
	output logic io_enable,
	output logic logic_full_speed,
	output logic logic_standby,
	output logic battery_on_indicator,
	output logic [APD_COUNT_W-1:0] apd_count
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic changed(input logic prev, input logic cur);
		return prev ^ cur;
	endfunction

	function automatic logic rising(input logic prev, input logic cur);
		return !prev && cur;
	endfunction

	logic [7:0] ctrl_first;
	logic [7:0] ctrl_second;
	logic turbo_off;
	logic apd_enable;
	logic ext_clk_q;
	logic ale_q;
	logic ale_edge;
	logic ext_rise;
	logic apd_done;
	logic wake;
	logic [4:0] array_in;
	logic [4:0] array_in_q;
	logic array_activity;
	logic [3:0] idle_cnt;
	pd_state_t pd_state;
	pd_state_t next_pd_state;

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	power_reg_apb #(
		.ADDR_W(ADDR_W)
	) power_reg_apb_i (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.ctrl_first(ctrl_first),
		.ctrl_second(ctrl_second)
	);

	assign turbo_off = ctrl_first[BIT_TURBO_OFF];
	assign apd_enable = ctrl_first[BIT_APD_ENABLE];

	// ----------------------------------------------------------------
	// Input gating toward array and macrocells
	// ----------------------------------------------------------------
	// Separate gates so the macrocells can keep the clock alone
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			array_clock <= 1'b0;
			macrocell_clock <= 1'b0;
		end else begin
			array_clock <= ext_logic_clock && !ctrl_first[BIT_ARRAY_CLK_OFF];
			macrocell_clock <= ext_logic_clock && !ctrl_first[BIT_MCELL_CLK_OFF];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			array_wr <= 1'b0;
			array_rd <= 1'b0;
			array_psen <= 1'b0;
			array_ale <= 1'b0;
		end else begin
			array_wr <= wr_strobe && !ctrl_second[BIT_WR_OFF];
			array_rd <= rd_strobe && !ctrl_second[BIT_RD_OFF];
			array_psen <= psen_strobe && !ctrl_second[BIT_PSEN_OFF];
			array_ale <= ale_strobe && !ctrl_second[BIT_ALE_OFF];
		end
	end

	// ----------------------------------------------------------------
	// Logic standby in low-power mode
	// ----------------------------------------------------------------
	// Only ungated inputs count; a blocked strobe cannot keep it awake
	assign array_in = {
		ext_logic_clock && !ctrl_first[BIT_ARRAY_CLK_OFF],
		wr_strobe && !ctrl_second[BIT_WR_OFF],
		rd_strobe && !ctrl_second[BIT_RD_OFF],
		psen_strobe && !ctrl_second[BIT_PSEN_OFF],
		ale_strobe && !ctrl_second[BIT_ALE_OFF]
	};

	always_comb begin
		array_activity = 1'b0;
		for (int i = 0; i < 5; i++) begin
			array_activity = array_activity || changed(array_in_q[i], array_in[i]);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			array_in_q <= '0;
		end else begin
			array_in_q <= array_in;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idle_cnt <= '0;
		end else if (array_activity) begin
			idle_cnt <= '0;
		end else if (idle_cnt != STANDBY_CYCLES) begin
			idle_cnt <= idle_cnt + 4'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			logic_standby <= 1'b0;
			logic_full_speed <= 1'b1;
		end else begin
			// Any passing edge powers the logic back up
			logic_standby <= turbo_off && !array_activity
				&& (idle_cnt == STANDBY_CYCLES);
			logic_full_speed <= !turbo_off;
		end
	end

	// ----------------------------------------------------------------
	// Automatic power-down
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_clk_q <= 1'b0;
			ale_q <= 1'b0;
		end else begin
			ext_clk_q <= ext_logic_clock;
			ale_q <= ale_strobe;
		end
	end

	assign ale_edge = changed(ale_q, ale_strobe);
	// Raw clock, so gating it from the logic never stalls the count
	assign ext_rise = rising(ext_clk_q, ext_logic_clock);

	apd_counter #(
		.CNT_W(APD_COUNT_W),
		.LIMIT(APD_LIMIT)
	) apd_counter_i (
		.pclk(pclk),
		.presetn(presetn),
		.enable(apd_enable),
		.tick(ext_rise),
		.restart(ale_edge),
		.count(apd_count),
		.done(apd_done)
	);

	assign wake = ale_edge || !chip_select_n || device_reset;

	always_comb begin
		next_pd_state = pd_state;
		unique case (pd_state)
			PS_ACTIVE: begin
				if (apd_enable && apd_done && !wake) begin
					next_pd_state = PS_DOWN;
				end
			end
			PS_DOWN: begin
				if (wake || !apd_enable) begin
					next_pd_state = PS_ACTIVE;
				end
			end
			default: begin
				next_pd_state = PS_ACTIVE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pd_state <= PS_ACTIVE;
			power_down_flag <= 1'b0;
		end else begin
			pd_state <= next_pd_state;
			power_down_flag <= (next_pd_state == PS_DOWN);
		end
	end

	// ----------------------------------------------------------------
	// Memory select and battery indicator
	// ----------------------------------------------------------------
	// Select has no effect on logic standby or gating; it enables accesses and wakes from power-down
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			memories_enable <= 1'b0;
			io_enable <= 1'b0;
			battery_on_indicator <= 1'b0;
		end else begin
			memories_enable <= !chip_select_n && (next_pd_state != PS_DOWN);
			io_enable <= !chip_select_n && (next_pd_state != PS_DOWN);
			battery_on_indicator <= battery_route && main_below_standby;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	standby_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
		(turbo_off && !array_activity) [*3] |=> logic_standby)
		else $error("standby not entered after quiet inputs");

	full_speed_a: assert property (@(posedge pclk) disable iff (!presetn)
		!turbo_off |=> !logic_standby && logic_full_speed)
		else $error("standby or low power while full speed selected");

	wake_up_a: assert property (@(posedge pclk) disable iff (!presetn)
		array_activity |=> !logic_standby)
		else $error("logic stayed in standby after input change");

	array_clk_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl_first[BIT_ARRAY_CLK_OFF] && $stable(ctrl_first) |-> !array_clock)
		else $error("array clock passed while gated");

	mcell_clk_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		!ctrl_first[BIT_MCELL_CLK_OFF] && $stable(ctrl_first)
		|-> macrocell_clock == $past(ext_logic_clock))
		else $error("macrocell clock not following input");

	strobe_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		$past(ctrl_second[BIT_WR_OFF]) |-> !array_wr && (array_ale == $past(ale_strobe
		&& !ctrl_second[BIT_ALE_OFF])))
		else $error("strobe gating wrong");

	pd_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(power_down_flag) |-> $past(apd_enable) && $past(apd_count) == APD_LIMIT)
		else $error("power-down raised before fifteen periods");

	pd_exit_a: assert property (@(posedge pclk) disable iff (!presetn)
		power_down_flag && wake |=> !power_down_flag)
		else $error("power-down not left on wake");

	apd_off_a: assert property (@(posedge pclk) disable iff (!presetn)
		!apd_enable |=> !power_down_flag)
		else $error("power-down while disabled");

	apd_count_a: assert property (@(posedge pclk) disable iff (!presetn)
		apd_enable && ext_rise && !ale_edge && apd_count != APD_LIMIT
		&& ctrl_first[BIT_APD_ENABLE] |=> apd_count == $past(apd_count) + 4'h1)
		else $error("power-down counter missed a clock period");

	mem_select_a: assert property (@(posedge pclk) disable iff (!presetn)
		chip_select_n |=> !memories_enable)
		else $error("memories enabled while deselected");

	standby_cov_c: cover property (@(posedge pclk) disable iff (!presetn)
		$rose(logic_standby));

	pd_enter_cov_c: cover property (@(posedge pclk) disable iff (!presetn)
		$rose(power_down_flag));

	pd_cs_exit_cov_c: cover property (@(posedge pclk) disable iff (!presetn)
		power_down_flag && !chip_select_n ##1 !power_down_flag);

	reg_write_cov_c: cover property (@(posedge pclk) disable iff (!presetn)
		psel && penable && pwrite && !pslverr);

endmodule

// ### sim/bus_partner.sv
`timescale 1ns/100ps
module bus_partner (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic run,
	input wire logic ale_pulse,
	output logic ext_logic_clock,
	output logic ale_strobe
);
	// Clock runs only in bursts and stands low between them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_logic_clock <= 1'b0;
		end else if (run) begin
			ext_logic_clock <= ~ext_logic_clock;
		end else begin
			ext_logic_clock <= 1'b0;
		end
	end

	// Address strobe idles low, follows the request one cycle later
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ale_strobe <= 1'b0;
		end else begin
			ale_strobe <= ale_pulse;
		end
	end
endmodule

// ### sim/pld_power_gating_control_tb.sv
`timescale 1ns/100ps
module pld_power_gating_control_tb;
	import pld_power_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, ext_logic_clock, ale_strobe;
	logic clk_run = 1'b0;
	logic ale_pulse = 1'b0;
	logic [2:0] strb = 3'h0;
	logic cs_n = 1'b1;
	logic dev_rst = 1'b0;
	logic below = 1'b0;
	logic route = 1'b0;
	logic array_clock, macrocell_clock, array_wr, array_rd, array_psen, array_ale;
	logic power_down_flag, memories_enable, io_enable, logic_full_speed, logic_standby;
	logic battery_on_indicator;
	logic [APD_COUNT_W-1:0] apd_count;
	logic [31:0] rd;
	logic err;
	int num_errors = 0;
	int n_compared = 0;

	initial begin
		forever #25 pclk = ~pclk;
	end

	bus_partner bus_partner_i (.pclk(pclk), .presetn(presetn), .run(clk_run),
		.ale_pulse(ale_pulse), .ext_logic_clock(ext_logic_clock), .ale_strobe(ale_strobe));

	pld_power_gating_control pld_power_gating_control_i (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ext_logic_clock(ext_logic_clock), .wr_strobe(strb[0]), .rd_strobe(strb[1]),
		.psen_strobe(strb[2]), .ale_strobe(ale_strobe), .chip_select_n(cs_n),
		.device_reset(dev_rst), .main_below_standby(below), .battery_route(route),
		.array_clock(array_clock), .macrocell_clock(macrocell_clock), .array_wr(array_wr),
		.array_rd(array_rd), .array_psen(array_psen), .array_ale(array_ale),
		.power_down_flag(power_down_flag), .memories_enable(memories_enable),
		.io_enable(io_enable), .logic_full_speed(logic_full_speed),
		.logic_standby(logic_standby), .battery_on_indicator(battery_on_indicator),
		.apd_count(apd_count));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic summarize();
		$display("Checks %0d, mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wait_cycles(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_regs();
		check("full_speed_rst", logic_full_speed, 1);
		apb(0, OFFSET_CTRL_FIRST, 0);
		check("first_rst", rd, 0);
		apb(1, OFFSET_CTRL_FIRST, 32'hFF);
		apb(0, OFFSET_CTRL_FIRST, 0);
		check("first_rb", rd, 32'h3A);
		apb(1, OFFSET_CTRL_SECOND, 32'hFF);
		apb(0, OFFSET_CTRL_SECOND, 0);
		check("second_rb", rd, 32'h3C);
		apb(0, 12'h008, 0);
		check("unmapped_err", err, 1);
		check("unmapped_data", rd, 0);
		apb(1, OFFSET_CTRL_FIRST, 0);
		apb(1, OFFSET_CTRL_SECOND, 0);
		$display("regs done");
	endtask

	task automatic t_clock(input logic [7:0] v);
		logic prev;
		apb(1, OFFSET_CTRL_FIRST, v);
		wait_cycles(3);
		repeat (4) begin
			@(posedge pclk);
			prev = ext_logic_clock;
			#1;
			check("array_clock", array_clock, v[4] ? 1'b0 : prev);
			check("mcell_clock", macrocell_clock, v[5] ? 1'b0 : prev);
		end
	endtask

	task automatic t_strobes();
		@(posedge pclk);
		strb <= 3'h7;
		ale_pulse <= 1'b1;
		for (int b = 2; b <= 5; b++) begin
			apb(1, OFFSET_CTRL_SECOND, 32'h1 << b);
			wait_cycles(3);
			check("array_wr", array_wr, b != 2);
			check("array_rd", array_rd, b != 3);
			check("array_psen", array_psen, b != 4);
			check("array_ale", array_ale, b != 5);
		end
		@(posedge pclk);
		strb <= 3'h0;
		ale_pulse <= 1'b0;
		apb(1, OFFSET_CTRL_SECOND, 0);
		$display("strobes done");
	endtask

	task automatic t_speed();
		clk_run <= 1'b1;
		apb(1, OFFSET_CTRL_FIRST, 32'h08);
		wait_cycles(6);
		check("full_speed_off", logic_full_speed, 0);
		check("standby_clk_runs", logic_standby, 0);
		apb(1, OFFSET_CTRL_FIRST, 32'h18);
		wait_cycles(6);
		check("standby_gated", logic_standby, 1);
		@(posedge pclk);
		strb <= 3'h1;
		wait_cycles(2);
		check("standby_wake", logic_standby, 0);
		@(posedge pclk);
		strb <= 3'h0;
		apb(1, OFFSET_CTRL_FIRST, 32'h10);
		wait_cycles(6);
		check("full_speed_on", logic_full_speed, 1);
		check("standby_turbo", logic_standby, 0);
		$display("speed done");
	endtask

	task automatic t_select();
		@(posedge pclk);
		cs_n <= 1'b0;
		route <= 1'b1;
		below <= 1'b1;
		wait_cycles(3);
		check("mem_en", memories_enable, 1);
		check("io_en", io_enable, 1);
		check("battery_on", battery_on_indicator, 1);
		@(posedge pclk);
		cs_n <= 1'b1;
		below <= 1'b0;
		wait_cycles(3);
		check("mem_dis", memories_enable, 0);
		check("io_dis", io_enable, 0);
		check("battery_off", battery_on_indicator, 0);
		@(posedge pclk);
		route <= 1'b0;
		below <= 1'b1;
		wait_cycles(3);
		check("battery_unrouted", battery_on_indicator, 0);
		@(posedge pclk);
		below <= 1'b0;
		$display("select done");
	endtask

	task automatic enter_pd();
		int n;
		apb(1, OFFSET_CTRL_FIRST, 0);
		clk_run <= 1'b1;
		apb(1, OFFSET_CTRL_SECOND, 32'h1C);
		apb(1, OFFSET_CTRL_FIRST, 32'h32);
		n = 0;
		while (power_down_flag !== 1'b1 && n < 60) begin
			@(posedge pclk);
			n++;
		end
		#1;
		check("pd_delay", n >= 27 && n <= 36, 1);
		check("pd_count", apd_count, 4'hF);
		check("pd_mem", memories_enable, 0);
		check("pd_array_clk", array_clock, 0);
	endtask

	task automatic t_pd();
		for (int k = 0; k < 3; k++) begin
			enter_pd();
			@(posedge pclk);
			if (k == 0) ale_pulse <= 1'b1;
			if (k == 1) cs_n <= 1'b0;
			if (k == 2) dev_rst <= 1'b1;
			wait_cycles(3);
			check("pd_exit", power_down_flag, 0);
			if (k == 1) check("pd_cs_mem", memories_enable, 1);
			@(posedge pclk);
			ale_pulse <= 1'b0;
			cs_n <= 1'b1;
			dev_rst <= 1'b0;
		end
		apb(1, OFFSET_CTRL_FIRST, 32'h30);
		wait_cycles(40);
		check("apd_off_flag", power_down_flag, 0);
		check("apd_off_count", apd_count, 0);
		clk_run <= 1'b0;
		$display("power down done");
	endtask

	initial begin
		#(50 * 20000);
		num_errors++;
		summarize();
	end

	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		#1;
		t_regs();
		clk_run <= 1'b1;
		t_clock(8'h00);
		t_clock(8'h10);
		t_clock(8'h20);
		$display("clock done");
		t_strobes();
		t_speed();
		t_select();
		t_pd();
		summarize();
	end
endmodule
